// ---- design/distributor_group_forward_enable.sv ----
// Group forwarding gate of an interrupt distributor with its register port
// What this block does
// [RULE1] Group 1 pending interrupts are forwarded only while enable bit 1 is set.
// [RULE2] Group 0 pending interrupts are forwarded only while enable bit 0 is set.
// [RULE3] First version with security: secure bit 1 aliases non-secure bit 0.
// [RULE4] Other registers work normally while either group enable is off.
// [RULE5] Set-pending writes and end-of-interrupt writes still act while forwarding is off.
// [RULE6] Edges on a disabled group still set pending; this is the fixed choice.
// [RULE7] First version: software-generated pending clears only on acknowledge, never by writes.
// [RULE8] Second version: software may set and clear software-generated pending state.
// [RULE9] Second version: software may set and clear active state.
// [RULE10] Second version: top pending in a disabled group blocks all forwarding.
// [RULE11] First version: the enabled group still forwards its own best interrupt.
// [RULE12] Acknowledge reads return the spurious number while nothing is forwarded.
// [RULE13] Software allows a short delay before enable changes take effect.
// [RULE14] Non-secure control bit 0 governs group 1 forwarding only.
// [RULE15] Control bits 31 to 2 read zero and ignore writes.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "fwd_defs.svh"
`default_nettype none
module distributor_group_forward_enable #(
	parameter int N_IRQ = 32,
	parameter int PRIO_W = 4,
	parameter int VERSION = 2,
	parameter bit SEC_EXT = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Register port
	input wire fwd_pkg::addr_t addr_i,
	input wire fwd_pkg::word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic secure_i,
	output fwd_pkg::word_t rdata_o,
	// Edge-triggered interrupt inputs, one-cycle pulses
	input wire logic [N_IRQ-1:0] irq_edge_i,
	// Forwarded interrupt towards the processor interface
	output logic fwd_valid_o,
	output fwd_pkg::irq_id_t fwd_id_o,
	output logic [PRIO_W-1:0] fwd_prio_o,
	output logic fwd_group_o,
	// Event interrupt
	output logic irq_o
);
	import fwd_pkg::*;

	localparam int IW = $clog2(N_IRQ);
	localparam int PWORDS = N_IRQ * PRIO_W / 32;
	localparam bit V1 = (VERSION == 1);
	localparam logic [1:0] CTRL_RST = `CTRL_RESET;

	logic grp0_en_ff;
	logic grp1_en_ff;
	logic [N_IRQ-1:0] group_ff;
	logic [PWORDS-1:0][31:0] prio_ff;
	logic [`EV_W-1:0] evst_ff;
	logic [`EV_W-1:0] evmk_ff;
	word_t rdata_ff;
	logic fwd_valid_ff;
	irq_id_t fwd_id_ff;
	logic [PRIO_W-1:0] fwd_prio_ff;
	logic fwd_group_ff;
	logic irq_ff;

	logic [N_IRQ-1:0] pend_w;
	logic [N_IRQ-1:0] act_w;
	logic [N_IRQ-1:0] set_pend_w;
	logic [N_IRQ-1:0] clr_pend_w;
	logic [N_IRQ-1:0] set_act_w;
	logic [N_IRQ-1:0] clr_act_w;
	logic [N_IRQ-1:0] ack_w;
	logic [N_IRQ-1:0] sgi_w;

	// Address decode
	wire sec_view = secure_i || !SEC_EXT;
	wire hit_ctrl = addr_i == `CTRL_OFS;
	wire hit_grp = addr_i == `GROUP_OFS;
	wire hit_setp = addr_i == `SETP_OFS;
	wire hit_clrp = addr_i == `CLRP_OFS;
	wire hit_seta = addr_i == `SETA_OFS;
	wire hit_clra = addr_i == `CLRA_OFS;
	wire hit_ack = addr_i == `ACK_OFS;
	wire hit_aack = addr_i == `AACK_OFS;
	wire hit_eoi = addr_i == `EOI_OFS || addr_i == `AEOI_OFS;
	wire hit_evst = addr_i == `EVST_OFS;
	wire hit_evmk = addr_i == `EVMK_OFS;
	wire [11:0] prio_rel = addr_i - `PRIO_OFS;
	wire hit_prio = addr_i >= `PRIO_OFS && prio_rel[11:2] < 10'(PWORDS) && prio_rel[1:0] == 2'h0;
	wire [9:0] prio_idx = prio_rel[11:2];

	// Control register: storage holds only the two enables
	wire wr_ctrl = wr_i && hit_ctrl;
	wire nxt_g0 = sec_view ? wdata_i[`CTRL_G0_BIT] : grp0_en_ff;
	// Non-secure copy bit 0 and secure bit 1 share one flop
	wire nxt_g1 = !sec_view ? wdata_i[`CTRL_G0_BIT] : (V1 && !SEC_EXT) ? wdata_i[`CTRL_G0_BIT] :
		wdata_i[`CTRL_G1_BIT]; // RULE3 RULE14
	wire [31:0] ctrl_rd = !sec_view ? {31'h0, grp1_en_ff} : (V1 && !SEC_EXT) ? {31'h0, grp0_en_ff} :
		{30'h0, grp1_en_ff, grp0_en_ff}; // RULE15

	// Arbitration over pending, not yet active interrupts
	wire [N_IRQ-1:0] grp_on = (group_ff & {N_IRQ{grp1_en_ff}}) | (~group_ff & {N_IRQ{grp0_en_ff}});
	// First version arbitrates among enabled groups only, second over all of them
	wire [N_IRQ-1:0] cand = pend_w & ~act_w & (V1 ? grp_on : {N_IRQ{1'b1}}); // RULE11
	wire best_any;
	wire [IW-1:0] best_id;
	wire [PRIO_W-1:0] best_prio;
	prio_pick #(.N(N_IRQ), .PW(PRIO_W), .IW(IW)) u_pick (
		.req_i(cand),
		.prio_i(prio_ff),
		.any_o(best_any),
		.id_o(best_id),
		.prio_o(best_prio)
	);
	wire best_grp = group_ff[best_id];
	// Second version: a top interrupt in a disabled group stops all forwarding and acknowledges
	wire fwd_ok = best_any && (best_grp ? grp1_en_ff : grp0_en_ff); // RULE1 RULE2 RULE10
	wire blocked = best_any && !fwd_ok;

	// Acknowledge: the alias acknowledges group 1 only
	wire rd_ack = rd_i && (hit_ack || hit_aack);
	wire ack_take = rd_ack && fwd_ok && (!hit_aack || best_grp);
	wire [9:0] ack_id = ack_take ? 10'(best_id) : `SPURIOUS_ID; // RULE12
	wire [9:0] eoi_id = wdata_i[9:0];

	// Per-interrupt controls; edges set pending whatever the group enable
	for (genvar i = 0; i < N_IRQ; i++) begin : g_irq
		assign sgi_w[i] = i < `NUM_SGI;
		assign ack_w[i] = ack_take && best_id == IW'(i);
		assign set_pend_w[i] = irq_edge_i[i] || (wr_i && hit_setp && wdata_i[i]); // RULE4 RULE5 RULE6
		assign clr_pend_w[i] = ack_w[i] || (wr_i && hit_clrp && wdata_i[i] && !(V1 && sgi_w[i])); // RULE7 RULE8
		assign set_act_w[i] = ack_w[i] || (!V1 && wr_i && hit_seta && wdata_i[i]); // RULE9
		assign clr_act_w[i] = (wr_i && hit_eoi && eoi_id == 10'(i)) ||
			(!V1 && wr_i && hit_clra && wdata_i[i]); // RULE5 RULE9
		irq_state_cell u_cell (
			.ref_clk_i(ref_clk_i),
			.srst_i(srst_i),
			.set_pend_i(set_pend_w[i]),
			.clr_pend_i(clr_pend_w[i]),
			.set_act_i(set_act_w[i]),
			.clr_act_i(clr_act_w[i]),
			.pend_o(pend_w[i]),
			.act_o(act_w[i])
		);
	end

	// Events: spurious acknowledge, edge into a disabled group, forwarding blocked
	wire edge_off = |(irq_edge_i & ~grp_on);
	wire [`EV_W-1:0] ev_set = {blocked, edge_off, rd_ack && !ack_take};
	wire [`EV_W-1:0] ev_clr = (wr_i && hit_evst) ? wdata_i[`EV_W-1:0] : '0;
	wire [`EV_W-1:0] nxt_evst = ev_set | (evst_ff & ~ev_clr);

	// Read multiplexer
	wire [31:0] rd_word = hit_ctrl ? ctrl_rd :
		hit_grp ? 32'(group_ff) :
		(hit_setp || hit_clrp) ? 32'(pend_w) :
		(hit_seta || hit_clra) ? 32'(act_w) :
		hit_prio ? prio_ff[prio_idx[$clog2(PWORDS+1)-1:0]] :
		(hit_ack || hit_aack) ? {22'h0, ack_id} :
		hit_evst ? 32'(evst_ff) :
		hit_evmk ? 32'(evmk_ff) : 32'h0;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			grp0_en_ff <= CTRL_RST[`CTRL_G0_BIT];
			grp1_en_ff <= CTRL_RST[`CTRL_G1_BIT];
		end else if (wr_ctrl) begin
			grp0_en_ff <= nxt_g0;
			grp1_en_ff <= nxt_g1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			group_ff <= '0;
			evmk_ff <= '0;
		end else begin
			if (wr_i && hit_grp)
				group_ff <= wdata_i[N_IRQ-1:0];
			if (wr_i && hit_evmk)
				evmk_ff <= wdata_i[`EV_W-1:0];
		end
	end

	for (genvar k = 0; k < PWORDS; k++) begin : g_prio
		always_ff @(posedge ref_clk_i) begin
			if (srst_i)
				prio_ff[k] <= 32'h0;
			else if (wr_i && hit_prio && prio_idx == 10'(k))
				prio_ff[k] <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			evst_ff <= '0;
			irq_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			evst_ff <= nxt_evst;
			irq_ff <= |(nxt_evst & evmk_ff);
			rdata_ff <= rd_i ? rd_word : 32'h0;
		end
	end

	// Registered forward outputs lag the enables by one cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			fwd_valid_ff <= 1'b0;
			fwd_id_ff <= `SPURIOUS_ID;
			fwd_prio_ff <= '1;
			fwd_group_ff <= 1'b0;
		end else begin
			fwd_valid_ff <= fwd_ok; // RULE1 RULE2 RULE10
			fwd_id_ff <= fwd_ok ? 10'(best_id) : `SPURIOUS_ID;
			fwd_prio_ff <= best_prio;
			fwd_group_ff <= best_grp;
		end
	end

	assign rdata_o = rdata_ff;
	assign fwd_valid_o = fwd_valid_ff;
	assign fwd_id_o = fwd_id_ff;
	assign fwd_prio_o = fwd_prio_ff;
	assign fwd_group_o = fwd_group_ff;
	assign irq_o = irq_ff;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	property p_grp1_gate;
		fwd_valid_o && fwd_group_o |-> $past(grp1_en_ff);
	endproperty
	a_grp1_gate: assert property (p_grp1_gate) else $error("group 1 forwarded while disabled"); // RULE1

	property p_grp0_gate;
		fwd_valid_o && !fwd_group_o |-> $past(grp0_en_ff);
	endproperty
	a_grp0_gate: assert property (p_grp0_gate) else $error("group 0 forwarded while disabled"); // RULE2

	property p_ns_alias;
		wr_i && hit_ctrl && !sec_view |=> grp1_en_ff == $past(wdata_i[0]) && $stable(grp0_en_ff);
	endproperty
	a_ns_alias: assert property (p_ns_alias) else $error("non-secure bit 0 not mapped to group 1"); // RULE14

	property p_setp_off;
		wr_i && hit_setp && !grp0_en_ff && !grp1_en_ff |=> (pend_w & $past(wdata_i[N_IRQ-1:0])) ==
			$past(wdata_i[N_IRQ-1:0]);
	endproperty
	a_setp_off: assert property (p_setp_off) else $error("set-pending ignored while disabled"); // RULE5

	property p_eoi;
		wr_i && hit_eoi && eoi_id < 10'(N_IRQ) |=> !act_w[$past(eoi_id[IW-1:0])];
	endproperty
	a_eoi: assert property (p_eoi) else $error("end of interrupt left active state"); // RULE5

	property p_sgi_keep;
		V1 && wr_i && hit_clrp && pend_w[0] && !ack_w[0] |=> pend_w[0];
	endproperty
	a_sgi_keep: assert property (p_sgi_keep) else $error("software cleared sgi pending"); // RULE7

	property p_spurious;
		rd_ack && !fwd_ok |=> rdata_o == 32'(`SPURIOUS_ID);
	endproperty
	a_spurious: assert property (p_spurious) else $error("acknowledge not spurious"); // RULE12

	// Ranks candidates on their own, so a picker or gate fault cannot hide behind best_grp
	wire [N_IRQ*PRIO_W-1:0] prio_flat = prio_ff;
	logic [N_IRQ-1:0] dis_top_w;
	for (genvar j = 0; j < N_IRQ; j++) begin : g_dis_top
		wire [PRIO_W-1:0] pj = prio_flat[j*PRIO_W +: PRIO_W];
		assign dis_top_w[j] = cand[j] && !grp_on[j] && (pj < best_prio || (pj == best_prio && IW'(j) <= best_id));
	end

	property p_block;
		!V1 && |dis_top_w |=> !fwd_valid_o;
	endproperty
	a_block: assert property (p_block) else $error("forwarded past a blocked top interrupt"); // RULE10

	property p_seta;
		!V1 && wr_i && hit_seta |=> (act_w & $past(wdata_i[N_IRQ-1:0])) == $past(wdata_i[N_IRQ-1:0]);
	endproperty
	a_seta: assert property (p_seta) else $error("set-active write lost"); // RULE9

	property p_ctrl_rsvd;
		rd_i && hit_ctrl |=> rdata_o[31:2] == 30'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits not zero"); // RULE15

	c_fwd: cover property (fwd_valid_o ##1 rd_ack && ack_take);
	c_block: cover property (blocked && (grp0_en_ff || grp1_en_ff));
	c_spur: cover property (rd_ack && !fwd_ok);
	c_irq: cover property (!irq_o ##1 irq_o);
endmodule
`default_nettype wire

// ---- design/irq_state_cell.sv ----
// Pending and active state of one interrupt
`timescale 1ns/100ps
`default_nettype none
module irq_state_cell (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Pending controls
	input wire logic set_pend_i,
	input wire logic clr_pend_i,
	// Active controls
	input wire logic set_act_i,
	input wire logic clr_act_i,
	// State
	output logic pend_o,
	output logic act_o
);
	logic nxt_pend;
	logic nxt_act;
	// A set in the same cycle as a clear wins, so no event is lost
	assign nxt_pend = set_pend_i | (pend_o & ~clr_pend_i);
	assign nxt_act = set_act_i | (act_o & ~clr_act_i);
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pend_o <= 1'b0;
			act_o <= 1'b0;
		end else begin
			pend_o <= nxt_pend;
			act_o <= nxt_act;
		end
	end
endmodule
`default_nettype wire

// ---- design/prio_pick.sv ----
// Picks the requesting interrupt with the lowest priority value
`timescale 1ns/100ps
`default_nettype none
module prio_pick #(
	parameter int N = 32,
	parameter int PW = 4,
	parameter int IW = 5
) (
	// Requests and their priorities
	input wire logic [N-1:0] req_i,
	input wire logic [N*PW-1:0] prio_i,
	// Winner
	output logic any_o,
	output logic [IW-1:0] id_o,
	output logic [PW-1:0] prio_o
);
	// Ties go to the lower number, which keeps the choice stable
	always_comb begin
		any_o = 1'b0;
		id_o = '0;
		prio_o = '1;
		for (int i = 0; i < N; i++) begin
			if (req_i[i] && (!any_o || prio_i[i*PW +: PW] < prio_o)) begin
				any_o = 1'b1;
				id_o = IW'(i);
				prio_o = prio_i[i*PW +: PW];
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/fwd_sink.sv ----
// Processor interface model that takes forwarded interrupts
`timescale 1ns/100ps
`default_nettype none
module fwd_sink (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Forwarded interrupt
	input wire logic fwd_valid_i,
	input wire fwd_pkg::irq_id_t fwd_id_i,
	// Count of forwards seen
	output logic [7:0] taken_o
);
	import fwd_pkg::*;
	logic valid_ff;
	// Transient forwards around enable changes are tolerated, not flagged
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			valid_ff <= 1'b0;
			taken_o <= 8'h00;
		end else begin
			valid_ff <= fwd_valid_i;
			if (fwd_valid_i && !valid_ff && fwd_id_i != 10'h3ff) begin
				taken_o <= taken_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench of the group forwarding gate
`timescale 1ns/100ps
`include "fwd_defs.svh"
`default_nettype none
module tb_top;
	import fwd_pkg::*;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	addr_t addr_i = 12'h000;
	word_t wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic secure_i = 1'b1;
	logic [31:0] irq_edge_i = 32'h0;
	word_t rdata_o;
	logic fwd_valid_o;
	irq_id_t fwd_id_o;
	logic [3:0] fwd_prio_o;
	logic fwd_group_o;
	logic irq_o;
	logic [7:0] taken;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	distributor_group_forward_enable i_distributor_group_forward_enable (.ref_clk_i(ref_clk_i),
		.srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.secure_i(secure_i), .rdata_o(rdata_o), .irq_edge_i(irq_edge_i), .fwd_valid_o(fwd_valid_o),
		.fwd_id_o(fwd_id_o), .fwd_prio_o(fwd_prio_o), .fwd_group_o(fwd_group_o), .irq_o(irq_o));
	fwd_sink i_fwd_sink (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .fwd_valid_i(fwd_valid_o),
		.fwd_id_i(fwd_id_o), .taken_o(taken));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Ceiling well above the roughly 110 cycles the sequence needs
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input addr_t a, input word_t d, input logic sec);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		secure_i <= sec;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input addr_t a, input logic sec, input word_t exp);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		secure_i <= sec;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask
	// Forward outputs settle two edges after the causing write
	task automatic fwd(input logic v, input logic [9:0] id);
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk({31'h0, fwd_valid_o}, {31'h0, v});
		if (v) begin
			chk({22'h0, fwd_id_o}, {22'h0, id});
		end
	endtask
	task automatic t_reset();
		rd(`CTRL_OFS, 1'b1, 32'h0);
		rd(12'h010, 1'b1, 32'h0);
		fwd(1'b0, 10'h0);
		chk({22'h0, fwd_id_o}, 32'h3ff);
		chk({28'h0, fwd_prio_o}, 32'hf);
	endtask
	task automatic t_group0();
		wr(`EVMK_OFS, 32'h7, 1'b1);
		@(posedge ref_clk_i);
		irq_edge_i <= 32'h8;
		@(posedge ref_clk_i);
		irq_edge_i <= 32'h0;
		rd(`SETP_OFS, 1'b1, 32'h8);
		chk({31'h0, irq_o}, 32'h1);
		fwd(1'b0, 10'h0);
		wr(`EVMK_OFS, 32'h0, 1'b1);
		wr(`EVST_OFS, 32'h7, 1'b1);
		fwd(1'b0, 10'h0);
		chk({31'h0, irq_o}, 32'h0);
		wr(`CTRL_OFS, 32'h1, 1'b1);
		fwd(1'b1, 10'h3);
		rd(`ACK_OFS, 1'b1, 32'h3);
		rd(`SETA_OFS, 1'b1, 32'h8);
		wr(`EOI_OFS, 32'h3, 1'b1);
		rd(`CLRA_OFS, 1'b1, 32'h0);
	endtask
	task automatic t_group1();
		wr(`GROUP_OFS, 32'h20, 1'b1);
		wr(`SETP_OFS, 32'h20, 1'b1);
		fwd(1'b0, 10'h0);
		wr(`CTRL_OFS, 32'h1, 1'b0);
		fwd(1'b1, 10'h5);
		chk({31'h0, fwd_group_o}, 32'h1);
		rd(`CTRL_OFS, 1'b1, 32'h3);
	endtask
	task automatic t_block();
		wr(`SETP_OFS, 32'h8, 1'b1);
		fwd(1'b1, 10'h3);
		wr(`CTRL_OFS, 32'h2, 1'b1);
		fwd(1'b0, 10'h0);
		rd(`ACK_OFS, 1'b1, 32'h3ff);
		rd(`AACK_OFS, 1'b1, 32'h3ff);
		rd(`EVST_OFS, 1'b1, 32'h5);
		wr(`EVST_OFS, 32'h7, 1'b1);
		rd(`EVST_OFS, 1'b1, 32'h4);
		wr(`CTRL_OFS, 32'hffffffff, 1'b1);
		rd(`CTRL_OFS, 1'b1, 32'h3);
		rd(`CTRL_OFS, 1'b0, 32'h1);
		wr(`CLRP_OFS, 32'h8, 1'b1);
		rd(`CLRP_OFS, 1'b1, 32'h20);
		fwd(1'b1, 10'h5);
		wr(`SETA_OFS, 32'h20, 1'b1);
		rd(`CLRA_OFS, 1'b1, 32'h20);
		fwd(1'b0, 10'h0);
		wr(`CLRA_OFS, 32'h20, 1'b1);
		fwd(1'b1, 10'h5);
		wr(`PRIO_OFS, 32'h00204000, 1'b1);
		rd(`PRIO_OFS, 1'b1, 32'h00204000);
		wr(`SETP_OFS, 32'h8, 1'b1);
		fwd(1'b1, 10'h5);
		chk({28'h0, fwd_prio_o}, 32'h2);
		chk({24'h0, taken}, 32'h4);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_group0();
		t_group1();
		t_block();
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- inc/fwd_defs.svh ----
// Register offsets, field positions and fixed values of the forwarding gate
`ifndef FWD_DEFS_SVH
`define FWD_DEFS_SVH
`define CTRL_OFS 12'h000
`define GROUP_OFS 12'h080
`define SETP_OFS 12'h200
`define CLRP_OFS 12'h280
`define SETA_OFS 12'h300
`define CLRA_OFS 12'h380
`define PRIO_OFS 12'h400
`define ACK_OFS 12'hc00
`define EOI_OFS 12'hc04
`define AACK_OFS 12'hc08
`define AEOI_OFS 12'hc0c
`define EVST_OFS 12'hd00
`define EVMK_OFS 12'hd04
`define CTRL_G0_BIT 0
`define CTRL_G1_BIT 1
`define CTRL_RESET 2'h0
`define SPURIOUS_ID 10'h3ff
`define NUM_SGI 16
`define EV_SPUR_BIT 0
`define EV_EDGE_BIT 1
`define EV_BLOCK_BIT 2
`define EV_W 3
`endif

// ---- inc/fwd_pkg.sv ----
// Types shared by the forwarding gate modules
package fwd_pkg;
	typedef logic [11:0] addr_t;
	typedef logic [31:0] word_t;
	typedef logic [9:0] irq_id_t;
endpackage
